/* File: inc/addr_resolver_consts.svh */
// Constants for the data space address resolver.
`ifndef ADDR_RESOLVER_CONSTS_SVH
`define ADDR_RESOLVER_CONSTS_SVH
`define SFR_SPACE_BASE 8'h80
`define BIT_AREA_BASE 8'h20
`define BANK_SIZE 8'h08
`define AUX_RAM_LAST 11'h6FF
`define PTR_REG_R0 3'h0
`define PTR_REG_R1 3'h1
`endif

/* File: inc/addr_resolver_pkg.sv */
// Types for the data space address resolver.
package addr_resolver_pkg;
  typedef enum logic [2:0] {
    MODE_REGISTER = 3'h0,
    MODE_DIRECT = 3'h1,
    MODE_INDIRECT = 3'h2,
    MODE_IMMEDIATE = 3'h3,
    MODE_BASE_INDEX = 3'h4
  } addr_mode_t;

  typedef enum logic [6:0] {
    TGT_NONE = 7'h01,
    TGT_BANK_REG = 7'h02,
    TGT_LOW_RAM = 7'h04,
    TGT_HIGH_RAM = 7'h08,
    TGT_SFR = 7'h10,
    TGT_AUX_RAM = 7'h20,
    TGT_CODE = 7'h40
  } target_t;

  typedef enum logic [1:0] {
    IND_POINTER = 2'h0,
    IND_EXT_BYTE = 2'h1,
    IND_EXT_WORD = 2'h2
  } indirect_kind_t;

  typedef struct packed {
    logic valid;
    addr_mode_t mode;
    indirect_kind_t ind_kind;
    logic is_dest;
    logic is_move;
    logic [7:0] operand;
    logic [15:0] base;
    logic [7:0] index;
    logic is_bit;
  } access_req_t;

  typedef struct packed {
    logic valid;
    target_t target;
    logic [15:0] addr;
    logic read_en;
    logic write_en;
    logic [2:0] bit_pos;
    logic error;
  } access_resp_t;
endpackage : addr_resolver_pkg

/* File: verilog/bit_address_mapper.sv */
// Maps a bit address onto a byte address and bit position.
`include "addr_resolver_consts.svh"
module bit_address_mapper (
  input wire logic [7:0] bit_addr,
  output logic [7:0] byte_addr,
  output logic [2:0] bit_pos,
  output logic in_sfr
);
  always_comb begin
    bit_pos = bit_addr[2:0];
    in_sfr = bit_addr[7];
    if (bit_addr[7]) begin
      byte_addr = {bit_addr[7:3], 3'h0}; // see RULE13
    end else begin
      byte_addr = `BIT_AREA_BASE + {4'h0, bit_addr[6:3]}; // see RULE11
    end
  end
endmodule : bit_address_mapper

/* File: verilog/data_space_address_resolver.sv */
// Operand address resolver that steers each access to its data space target.
// Operation
// RULE1 - Five addressing methods: register, direct, indirect, immediate, base plus index.
// RULE2 - Only register, direct and indirect methods may be write targets.
// RULE3 - Non-move operations read the destination before writing it.
// RULE4 - Bank registers reachable by register, direct and indirect addressing.
// RULE5 - RAM bytes 0 to 127 reachable directly and indirectly.
// RULE6 - RAM 128 to 255 indirect only; direct there goes to SFRs.
// RULE7 - Expanded RAM 0 to 1791 only via the external-move class.
// RULE8 - SFRs only by direct addressing at 128 to 255.
// RULE9 - External data memory only by indirect addressing through a pointer.
// RULE10 - Code table reads use base register plus index register.
// RULE11 - Bit addresses 00 to 7F map onto bytes 20H to 2FH, LSB first.
// RULE12 - Banks zero to three occupy bytes 00H to 1FH, eight each.
// RULE13 - Bit addresses from 80H select SFRs at multiples of eight.
`include "addr_resolver_consts.svh"
module data_space_address_resolver (
  input wire logic clk,
  input wire logic reset,
  input wire addr_resolver_pkg::access_req_t req,
  input wire logic [1:0] bank_sel,
  input wire logic [7:0] pointer_value,
  output addr_resolver_pkg::access_resp_t resp,
  output logic write_pending
);
  logic [7:0] bit_byte;
  logic [2:0] bit_pos;
  logic bit_in_sfr;
  addr_resolver_pkg::access_resp_t next_resp;
  addr_resolver_pkg::access_resp_t held;
  addr_resolver_pkg::access_resp_t next_held;
  logic next_write_pending;

  bit_address_mapper u_bit_map (
    .bit_addr(req.operand),
    .byte_addr(bit_byte),
    .bit_pos(bit_pos),
    .in_sfr(bit_in_sfr)
  );

  // Decode of one request; the write half of a read-modify-write is issued a cycle later.
  always_comb begin
    next_resp = '0;
    next_resp.target = addr_resolver_pkg::TGT_NONE;
    next_held = held;
    next_write_pending = 1'b0;
    if (write_pending) begin
      // The held write goes out first; a request in this cycle is refused.
      next_resp = held;
      next_resp.read_en = 1'b0;
      next_resp.write_en = 1'b1; // see RULE3
      next_resp.valid = 1'b1;
      next_resp.error = req.valid;
    end else if (req.valid) begin
      next_resp.valid = 1'b1;
      case (req.mode) // see RULE1
        addr_resolver_pkg::MODE_REGISTER: begin
          next_resp.target = addr_resolver_pkg::TGT_BANK_REG; // see RULE4
          next_resp.addr = {8'h00, {bank_sel, req.operand[2:0]}}; // see RULE12
        end
        addr_resolver_pkg::MODE_DIRECT: begin
          if (req.is_bit) begin
            next_resp.bit_pos = bit_pos;
            next_resp.addr = {8'h00, bit_byte};
            next_resp.target = bit_in_sfr ? addr_resolver_pkg::TGT_SFR
                                          : addr_resolver_pkg::TGT_LOW_RAM;
          end else if (req.operand >= `SFR_SPACE_BASE) begin
            next_resp.target = addr_resolver_pkg::TGT_SFR; // see RULE6 see RULE8
            next_resp.addr = {8'h00, req.operand};
          end else begin
            // Direct access to bytes 00H-1FH also lands on the bank registers.
            next_resp.target = (req.operand < (`BANK_SIZE << 2)) ?
                addr_resolver_pkg::TGT_BANK_REG : addr_resolver_pkg::TGT_LOW_RAM; // see RULE5
            next_resp.addr = {8'h00, req.operand};
          end
        end
        addr_resolver_pkg::MODE_INDIRECT: begin
          case (req.ind_kind)
            addr_resolver_pkg::IND_POINTER: begin
              // Pointer indirect never reaches SFRs; pointers from 80H reach upper RAM.
              next_resp.addr = {8'h00, pointer_value};
              if (pointer_value >= `SFR_SPACE_BASE) begin
                next_resp.target = addr_resolver_pkg::TGT_HIGH_RAM; // see RULE6 see RULE8
              end else if (pointer_value < (`BANK_SIZE << 2)) begin
                next_resp.target = addr_resolver_pkg::TGT_BANK_REG; // see RULE4
              end else begin
                next_resp.target = addr_resolver_pkg::TGT_LOW_RAM; // see RULE5
              end
            end
            addr_resolver_pkg::IND_EXT_BYTE, addr_resolver_pkg::IND_EXT_WORD: begin
              // External-move class: low addresses hit expanded RAM, others go off chip.
              next_resp.addr = (req.ind_kind == addr_resolver_pkg::IND_EXT_WORD) ?
                  req.base : {8'h00, pointer_value}; // see RULE9
              next_resp.target = (next_resp.addr <= {5'h00, `AUX_RAM_LAST}) ?
                  addr_resolver_pkg::TGT_AUX_RAM : addr_resolver_pkg::TGT_NONE; // see RULE7
            end
            default: begin
              next_resp.error = 1'b1;
            end
          endcase
        end
        addr_resolver_pkg::MODE_IMMEDIATE: begin
          next_resp.target = addr_resolver_pkg::TGT_NONE;
          next_resp.addr = {8'h00, req.operand};
        end
        addr_resolver_pkg::MODE_BASE_INDEX: begin
          next_resp.target = addr_resolver_pkg::TGT_CODE;
          next_resp.addr = req.base + {8'h00, req.index}; // see RULE10
        end
        default: begin
          next_resp.error = 1'b1;
        end
      endcase
      if (req.is_dest && (req.mode == addr_resolver_pkg::MODE_IMMEDIATE ||
          req.mode == addr_resolver_pkg::MODE_BASE_INDEX)) begin
        next_resp.error = 1'b1; // see RULE2
      end else if (req.is_dest && !req.is_move) begin
        next_resp.read_en = 1'b1; // see RULE3
        next_held = next_resp;
        next_write_pending = !next_resp.error;
      end else if (req.is_dest) begin
        next_resp.write_en = 1'b1;
      end else begin
        next_resp.read_en = 1'b1;
      end
      if (next_resp.error) begin
        next_resp.read_en = 1'b0;
        next_resp.write_en = 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      resp <= '0;
      held <= '0;
      write_pending <= 1'b0;
    end else begin
      resp <= next_resp;
      held <= next_held;
      write_pending <= next_write_pending;
    end
  end

  a_dest_no_write: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.is_dest && req.mode == addr_resolver_pkg::MODE_IMMEDIATE
    |=> resp.error && !resp.write_en) // see RULE2
    else $error("immediate destination was not refused");
  a_rmw_order: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.is_dest && !req.is_move &&
    req.mode == addr_resolver_pkg::MODE_REGISTER
    |=> resp.read_en ##1 (resp.write_en && resp.addr == $past(resp.addr))) // see RULE3
    else $error("read-modify-write order broken");
  a_direct_sfr: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_DIRECT &&
    !req.is_bit && req.operand[7]
    |=> resp.target == addr_resolver_pkg::TGT_SFR) // see RULE8
    else $error("direct upper address missed SFR space");
  a_indirect_high: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_INDIRECT &&
    req.ind_kind == addr_resolver_pkg::IND_POINTER && pointer_value[7]
    |=> resp.target == addr_resolver_pkg::TGT_HIGH_RAM) // see RULE6
    else $error("indirect upper address reached SFR space");
  a_bank_addr: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_REGISTER
    |=> resp.addr == {8'h00, $past(bank_sel), $past(req.operand[2:0])}) // see RULE12
    else $error("bank register address wrong");
  a_table_sum: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_BASE_INDEX
    |=> resp.target == addr_resolver_pkg::TGT_CODE &&
        resp.addr == $past(req.base) + {8'h00, $past(req.index)}) // see RULE10
    else $error("table address wrong");
  a_bit_ram: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_DIRECT &&
    req.is_bit && !req.operand[7]
    |=> resp.addr == 16'h0020 + {12'h000, $past(req.operand[6:3])} &&
        resp.bit_pos == $past(req.operand[2:0])) // see RULE11
    else $error("bit address mapped wrong");
  a_bit_sfr: assert property (@(posedge clk) disable iff (reset)
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_DIRECT &&
    req.is_bit && req.operand[7]
    |=> resp.addr[2:0] == 3'h0 && resp.target == addr_resolver_pkg::TGT_SFR) // see RULE13
    else $error("SFR bit address wrong");
  a_aux_range: assert property (@(posedge clk) disable iff (reset)
    resp.target == addr_resolver_pkg::TGT_AUX_RAM |-> resp.addr <= 16'h06FF) // see RULE7
    else $error("expanded RAM address out of range");
  c_rmw: cover property (@(posedge clk) disable iff (reset) write_pending ##1 resp.write_en);
  c_sfr: cover property (@(posedge clk) disable iff (reset)
    resp.target == addr_resolver_pkg::TGT_SFR);
  c_aux: cover property (@(posedge clk) disable iff (reset)
    resp.target == addr_resolver_pkg::TGT_AUX_RAM);
  c_refused: cover property (@(posedge clk) disable iff (reset)
    write_pending && req.valid);
  c_code: cover property (@(posedge clk) disable iff (reset)
    resp.target == addr_resolver_pkg::TGT_CODE);

  // A request that meets a pending write is refused, but the write still goes out.
  a_refused_error: assert property (@(posedge clk) disable iff (reset) // see RULE3
    write_pending && req.valid
    |=> resp.error && resp.write_en && !resp.read_en)
    else $error("request during pending write was not refused");

  a_held_write: assert property (@(posedge clk) disable iff (reset) // see RULE3
    write_pending
    |=> resp.valid && resp.write_en && !resp.read_en)
    else $error("held write was not issued");

  a_pending_once: assert property (@(posedge clk) disable iff (reset) // see RULE3
    write_pending
    |=> !write_pending)
    else $error("pending write lasted more than one cycle");

  a_rmw_pending: assert property (@(posedge clk) disable iff (reset) // see RULE3
    req.valid && !write_pending && req.is_dest && !req.is_move &&
    req.mode == addr_resolver_pkg::MODE_DIRECT
    |=> write_pending && resp.read_en && !resp.write_en)
    else $error("direct read-modify-write did not read first");

  a_move_write: assert property (@(posedge clk) disable iff (reset) // see RULE2
    req.valid && !write_pending && req.is_dest && req.is_move &&
    (req.mode == addr_resolver_pkg::MODE_REGISTER ||
    req.mode == addr_resolver_pkg::MODE_DIRECT)
    |=> resp.write_en && !resp.read_en && !resp.error)
    else $error("move destination was not written");

  a_base_dest: assert property (@(posedge clk) disable iff (reset) // see RULE2
    req.valid && !write_pending && req.is_dest &&
    req.mode == addr_resolver_pkg::MODE_BASE_INDEX
    |=> resp.error && !resp.write_en && !resp.read_en)
    else $error("table destination was not refused");

  a_source_read: assert property (@(posedge clk) disable iff (reset) // see RULE1
    req.valid && !write_pending && !req.is_dest &&
    req.mode == addr_resolver_pkg::MODE_REGISTER
    |=> resp.read_en && !resp.write_en)
    else $error("register source was not read");

  a_imm_none: assert property (@(posedge clk) disable iff (reset) // see RULE1
    req.valid && !write_pending && !req.is_dest &&
    req.mode == addr_resolver_pkg::MODE_IMMEDIATE
    |=> resp.target == addr_resolver_pkg::TGT_NONE && resp.read_en)
    else $error("immediate operand steered to a space");

  a_idle_quiet: assert property (@(posedge clk) disable iff (reset) // see RULE1
    !req.valid && !write_pending
    |=> !resp.valid)
    else $error("answer without a request");

  a_direct_low: assert property (@(posedge clk) disable iff (reset) // see RULE5
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_DIRECT &&
    !req.is_bit && req.operand >= 8'h20 && !req.operand[7]
    |=> resp.target == addr_resolver_pkg::TGT_LOW_RAM &&
        resp.addr == {8'h00, $past(req.operand)})
    else $error("direct lower address missed RAM");

  a_direct_bank: assert property (@(posedge clk) disable iff (reset) // see RULE4
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_DIRECT &&
    !req.is_bit && req.operand < 8'h20
    |=> resp.target == addr_resolver_pkg::TGT_BANK_REG)
    else $error("direct bank address missed the banks");

  a_indirect_low: assert property (@(posedge clk) disable iff (reset) // see RULE5
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_INDIRECT &&
    req.ind_kind == addr_resolver_pkg::IND_POINTER &&
    pointer_value >= 8'h20 && !pointer_value[7]
    |=> resp.target == addr_resolver_pkg::TGT_LOW_RAM)
    else $error("indirect lower address missed RAM");

  a_indirect_bank: assert property (@(posedge clk) disable iff (reset) // see RULE4
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_INDIRECT &&
    req.ind_kind == addr_resolver_pkg::IND_POINTER && pointer_value < 8'h20
    |=> resp.target == addr_resolver_pkg::TGT_BANK_REG)
    else $error("indirect bank address missed the banks");

  a_no_sfr_indirect: assert property (@(posedge clk) disable iff (reset) // see RULE8
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_INDIRECT
    |=> resp.target != addr_resolver_pkg::TGT_SFR)
    else $error("indirect access reached SFR space");

  a_ext_byte: assert property (@(posedge clk) disable iff (reset) // see RULE9
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_INDIRECT &&
    req.ind_kind == addr_resolver_pkg::IND_EXT_BYTE
    |=> resp.target == addr_resolver_pkg::TGT_AUX_RAM &&
        resp.addr == {8'h00, $past(pointer_value)})
    else $error("pointer external move address wrong");

  // Word pointers beyond the expanded RAM leave the chip, so no internal target.
  a_ext_word_off: assert property (@(posedge clk) disable iff (reset) // see RULE7
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_INDIRECT &&
    req.ind_kind == addr_resolver_pkg::IND_EXT_WORD && req.base > 16'h06ff
    |=> resp.target == addr_resolver_pkg::TGT_NONE)
    else $error("word external move above expanded RAM kept on chip");

  a_sfr_bit_pos: assert property (@(posedge clk) disable iff (reset) // see RULE13
    req.valid && !write_pending && req.mode == addr_resolver_pkg::MODE_DIRECT &&
    req.is_bit && req.operand[7]
    |=> resp.bit_pos == $past(req.operand[2:0]) && resp.addr[15:8] == 8'h00 &&
        resp.addr[7:3] == $past(req.operand[7:3]))
    else $error("SFR bit position wrong");
endmodule : data_space_address_resolver

/* File: tb/core_ptr_model.sv */
// Model of the core's pointer registers R0 and R1 in every bank.
module core_ptr_model (
  input wire logic [1:0] bank_sel,
  input wire logic ptr_sel,
  output logic [7:0] pointer_value
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] regs [8];
  // Six of the eight pointers sit on a space boundary, where a wrong compare shows first; 05H and C3H do not.
  initial regs = '{8'h1f, 8'h7f, 8'h80, 8'hff, 8'h20, 8'h00, 8'h05, 8'hc3};
  // The selected bank's R0 or R1 forms the indirect address.
  assign pointer_value = regs[{bank_sel, ptr_sel}];
endmodule : core_ptr_model

/* File: tb/data_space_address_resolver_bench.sv */
// Self-checking bench for the data space address resolver.
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  $display("[FAIL] %s exp %h got %h", n, e, g); n_mismatch++; end end
`define PK(x) addr_resolver_pkg::x
module data_space_address_resolver_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0;
  logic reset = 1;
  `PK(access_req_t) req = '0;
  logic [1:0] bank_sel = 2'h0;
  logic ptr_sel = 0;
  logic [7:0] pointer_value;
  `PK(access_resp_t) resp;
  logic write_pending;
  int n_mismatch = 0;
  int checked = 0;
  data_space_address_resolver i_dut (.clk(clk), .reset(reset), .req(req),
    .bank_sel(bank_sel), .pointer_value(pointer_value), .resp(resp),
    .write_pending(write_pending));
  core_ptr_model i_core (.bank_sel(bank_sel), .ptr_sel(ptr_sel),
    .pointer_value(pointer_value));
  initial begin
    forever #5 clk = ~clk;
  end
  function automatic `PK(target_t) space(input logic [7:0] v, input logic hi);
    if (v < 8'h20) return `PK(TGT_BANK_REG);
    if (v < 8'h80) return `PK(TGT_LOW_RAM);
    return hi ? `PK(TGT_HIGH_RAM) : `PK(TGT_SFR);
  endfunction : space
  // One request, judged in the single cycle its answer stands.
  // f is {dest, move, bit}; e is {read, write, error}.
  task automatic go(input `PK(addr_mode_t) m, input logic [7:0] op, input logic [15:0] b,
    input logic [1:0] k, input logic [2:0] f, input `PK(target_t) t,
    input logic [15:0] a, input logic [2:0] e);
    @(posedge clk);
    req <= '{1'b1, m, `PK(indirect_kind_t)'(k), f[2], f[1], op, b, op, f[0]};
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    `CHK("valid", 1'b1, resp.valid)
    `CHK("enables", e, {resp.read_en, resp.write_en, resp.error})
    if (!e[0]) `CHK("target", t, resp.target)
    if (!e[0] && t != `PK(TGT_NONE)) `CHK("addr", a, resp.addr)
    if (f[0]) `CHK("bit_pos", op[2:0], resp.bit_pos)
  endtask : go
  task automatic t_register;
    for (int b = 0; b < 4; b++) begin
      @(posedge clk);
      bank_sel <= 2'(b);
      for (int n = 0; n < 8; n += 7) begin
        go(`PK(MODE_REGISTER), 8'(n), 0, 0, 0, `PK(TGT_BANK_REG), 16'(b * 8 + n), 3'h4);
      end
    end
    $display("t_register end");
  endtask : t_register
  task automatic t_direct;
    logic [7:0] v [6] = '{8'h00, 8'h1f, 8'h20, 8'h7f, 8'h80, 8'hff};
    foreach (v[i]) go(`PK(MODE_DIRECT), v[i], 0, 0, 0, space(v[i], 0), 16'(v[i]), 3'h4);
    $display("t_direct end");
  endtask : t_direct
  task automatic t_indirect;
    for (int p = 0; p < 8; p++) begin
      @(posedge clk);
      {bank_sel, ptr_sel} <= 3'(p);
      #1;
      go(`PK(MODE_INDIRECT), 0, 0, 0, 0, space(pointer_value, 1), 16'(pointer_value), 3'h4);
      go(`PK(MODE_INDIRECT), 0, 0, 1, 0, `PK(TGT_AUX_RAM), 16'(pointer_value), 3'h4);
    end
    // The word pointer reaches the expanded RAM only up to its last byte.
    go(`PK(MODE_INDIRECT), 0, 16'h06ff, 2, 0, `PK(TGT_AUX_RAM), 16'h06ff, 3'h4);
    go(`PK(MODE_INDIRECT), 0, 16'h0700, 2, 0, `PK(TGT_NONE), 0, 3'h4);
    go(`PK(MODE_BASE_INDEX), 8'hff, 16'h1234, 0, 0, `PK(TGT_CODE), 16'h1333, 3'h4);
    go(`PK(MODE_IMMEDIATE), 8'h5a, 0, 0, 0, `PK(TGT_NONE), 0, 3'h4);
    $display("t_indirect end");
  endtask : t_indirect
  task automatic t_bits;
    logic [7:0] v [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
    foreach (v[i]) go(`PK(MODE_DIRECT), v[i], 0, 0, 1, v[i][7] ? `PK(TGT_SFR) : `PK(TGT_LOW_RAM),
      16'(v[i][7] ? v[i] & 8'hf8 : 8'h20 + 8'(v[i][6:3])), 3'h4);
    $display("t_bits end");
  endtask : t_bits
  task automatic t_rmw;
    go(`PK(MODE_REGISTER), 8'h03, 0, 0, 4, `PK(TGT_BANK_REG), 16'h001b, 3'h4);
    `CHK("pending", 1'b1, write_pending)
    @(posedge clk);
    #1;
    `CHK("held write", 3'h2, {resp.read_en, resp.write_en, resp.error})
    `CHK("held addr", 16'h001b, resp.addr)
    go(`PK(MODE_DIRECT), 8'h40, 0, 0, 6, `PK(TGT_LOW_RAM), 16'h0040, 3'h2);
    go(`PK(MODE_IMMEDIATE), 8'h01, 0, 0, 4, `PK(TGT_NONE), 0, 3'h1);
    go(`PK(MODE_BASE_INDEX), 8'h01, 16'h0100, 0, 4, `PK(TGT_NONE), 0, 3'h1);
    // A request that arrives while the held write is due must be refused.
    @(posedge clk);
    req <= '{1'b1, `PK(MODE_REGISTER), `PK(IND_POINTER), 1'b1, 1'b0, 8'h03, 16'h0000,
      8'h03, 1'b0};
    @(posedge clk);
    req.operand <= 8'h40;
    #1;
    `CHK("rmw read", 3'h4, {resp.read_en, resp.write_en, resp.error})
    `CHK("pending again", 1'b1, write_pending)
    @(posedge clk);
    req.valid <= 1'b0;
    #1;
    `CHK("refused", 3'h3, {resp.read_en, resp.write_en, resp.error})
    `CHK("refused addr", 16'h001b, resp.addr)
    `CHK("refused target", `PK(TGT_BANK_REG), resp.target)
    $display("t_rmw end");
  endtask : t_rmw
  task automatic summarize;
    $display("checked %0d n_mismatch %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : summarize
  initial begin
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_register();
    t_direct();
    t_indirect();
    t_bits();
    t_rmw();
    summarize();
  end
  // A hung run is cut short at 200000 ns, far beyond the 108 cycles a normal run takes.
  initial begin
    #200000;
    n_mismatch++;
    summarize();
  end
endmodule : data_space_address_resolver_bench
